/* File: hdl/pineu_top.sv */
// Purpose: PIN enable/disable/verify/unblock engine behind AXI4-Lite
// Assumes: Retry counters and stored codes are cleared only by arst_n,
//          which stands for first power-up; card resets are a command
// Notes:   One command executes in a single cycle after its write
//
// Overview of operation
// - Wrong enable code decrements, stays disabled, 63Cx
// - PIN counter survives card reset, reaches C0
// - Blocked PIN: enable or verify returns 6983
// - Correct enable restores three tries, enables, 9000
// - Empty data field on verify, enable, disable or unblock only reports retry count
// - Enabled unverified read refused 6982; disabled 9000
// - Blocked and enabled: reads refused until unblock
// - Blocked and disabled: reads still granted
// - Enable while enabled is refused with error
// - Status answer holds tag 90 enable object
// - Unblock restores PIN counter and writes PIN in the same cycle
// - Unblock runs whether or not PIN blocked
// - Good unblock: new PIN, ten and three
// - After unblock PIN enabled and satisfied
// - Wrong unblock decrements only unblock counter
// - Ten wrong unblocks block the unblock code
// - Wrong unblock leaves PIN status untouched
// - Failed comparison returns error, not 9000
// - Enable refused when already enabled or blocked
// - Three wrong PINs across sessions block PIN
`timescale 1ns/10ps

module pineu_top
  import pineu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Engine sequencing
  typedef enum logic {ST_IDLE, ST_EXEC} pineu_state_t;

  pineu_state_t state_r;        // Idle or executing
  pineu_state_t state_nxt;      // Next engine state
  pineu_cmd_t   cmd_r;          // Latched command
  pineu_sw_t    sw_r;           // Last status word
  pineu_sw_t    sw_nxt;         // Status word being formed
  logic [31:0]  pin_in_r;       // Presented PIN
  logic [31:0]  unblk_in_r;     // Presented unblock code
  logic [31:0]  newpin_r;       // Replacement PIN
  logic [31:0]  pin_ref_r;      // Stored PIN reference
  logic [31:0]  pin_ref_nxt;
  logic [3:0]   pin_cnt_r;      // PIN tries left, persistent
  logic [3:0]   pin_cnt_nxt;
  logic [3:0]   unblk_cnt_r;    // Unblock tries left, persistent
  logic [3:0]   unblk_cnt_nxt;
  logic         enabled_r;      // PIN check switched on
  logic         enabled_nxt;
  logic         verified_r;     // Access level met this session
  logic         verified_nxt;
  logic         done_r;         // Last command finished
  logic         cmd_go_r;       // Command register just written

  // AXI output flops
  logic         awready_r;
  logic         wready_r;
  logic         bvalid_r;
  logic [1:0]   bresp_r;
  logic         arready_r;
  logic         rvalid_r;
  logic [31:0]  rdata_r;
  logic [1:0]   rresp_r;

  // Merge write data into a word by byte strobes
  function automatic logic [31:0] pineu_merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  be
  );
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Retry count answer: group 63, detail C plus count
  function automatic pineu_sw_t pineu_cnt_sw(input logic [3:0] cnt);
    pineu_sw_t s;
    s.sw1 = PINEU_SW1_CNT;
    s.sw2 = {PINEU_SW2_CNT_HI, cnt};
    return s;
  endfunction

  // Derived PIN and access state
  wire pin_blk    = (pin_cnt_r == 4'h0);
  wire unblk_blk  = (unblk_cnt_r == 4'h0);
  wire pin_ok     = (pin_in_r == pin_ref_r);
  wire unblk_ok   = (unblk_in_r == PINEU_UNBLK_RST);
  // Disabled PIN grants access even when blocked; enabled needs verify
  wire access_ok  = !enabled_r || verified_r;
  wire [3:0] pin_dec   = pin_cnt_r - 4'h1;
  wire [3:0] unblk_dec = unblk_cnt_r - 4'h1;
  wire [7:0] ps_byte   = enabled_r ? PINEU_PS_ENABLED : PINEU_PS_DISABLED;

  // Write channel decode
  wire wr_start  = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
  wire wr_fire   = awready_r;     // Valids are held until taken
  wire sel_w_cmd    = (s_axi_awaddr == PINEU_OFF_CMD);
  wire sel_w_pin    = (s_axi_awaddr == PINEU_OFF_PIN);
  wire sel_w_unblk  = (s_axi_awaddr == PINEU_OFF_UNBLK);
  wire sel_w_newpin = (s_axi_awaddr == PINEU_OFF_NEWPIN);
  wire sel_w_ro     = (s_axi_awaddr == PINEU_OFF_SW) ||
                      (s_axi_awaddr == PINEU_OFF_STATE) ||
                      (s_axi_awaddr == PINEU_OFF_RESP);
  wire w_mapped  = sel_w_cmd || sel_w_pin || sel_w_unblk || sel_w_newpin ||
                   sel_w_ro;
  // A command needs the low byte and an idle engine
  wire cmd_take  = wr_fire && sel_w_cmd && s_axi_wstrb[0] &&
                   (state_r == ST_IDLE) && !cmd_go_r;

  // Read channel decode
  wire rd_start  = s_axi_arvalid && !arready_r && !rvalid_r;
  wire rd_fire   = arready_r;
  wire [31:0] state_word = {12'h000, unblk_cnt_r, 4'h0, pin_cnt_r, 3'h0,
                            unblk_blk, pin_blk, verified_r, enabled_r,
                            done_r};
  wire [31:0] resp_word  = {16'h0000, PINEU_PS_TAG, ps_byte};
  wire [31:0] cmd_word   = {23'h000000, cmd_r.empty, 5'h00, cmd_r.op};
  wire r_mapped  = (s_axi_araddr <= PINEU_OFF_RESP) &&
                   (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rd_mux =
    (s_axi_araddr == PINEU_OFF_CMD)    ? cmd_word :
    (s_axi_araddr == PINEU_OFF_PIN)    ? pin_in_r :
    (s_axi_araddr == PINEU_OFF_UNBLK)  ? unblk_in_r :
    (s_axi_araddr == PINEU_OFF_NEWPIN) ? newpin_r :
    (s_axi_araddr == PINEU_OFF_SW)     ? {16'h0000, sw_r} :
    (s_axi_araddr == PINEU_OFF_STATE)  ? state_word :
    (s_axi_araddr == PINEU_OFF_RESP)   ? resp_word : 32'h00000000;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Write address and data are taken together, one cycle after both
  // are offered; waiting for both keeps the slave free of buffers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= PINEU_RESP_OKAY;
    end else begin
      awready_r <= wr_start;
      wready_r  <= wr_start;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= w_mapped ? PINEU_RESP_OKAY : PINEU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read answer registered from the decode mux
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= PINEU_RESP_OKAY;
    end else begin
      arready_r <= rd_start;
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r  <= r_mapped ? rd_mux : 32'h00000000;
        rresp_r  <= r_mapped ? PINEU_RESP_OKAY : PINEU_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Operand registers written by software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_in_r   <= 32'h00000000;
      unblk_in_r <= 32'h00000000;
      newpin_r   <= 32'h00000000;
    end else if (wr_fire) begin
      if (sel_w_pin) begin
        pin_in_r <= pineu_merge(pin_in_r, s_axi_wdata, s_axi_wstrb);
      end
      if (sel_w_unblk) begin
        unblk_in_r <= pineu_merge(unblk_in_r, s_axi_wdata, s_axi_wstrb);
      end
      // Host supplies code and replacement before the command
      if (sel_w_newpin) begin
        newpin_r <= pineu_merge(newpin_r, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  // Command latch and one-cycle trigger
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r    <= '{empty: 1'b0, op: PINEU_OP_STATUS};
      cmd_go_r <= 1'b0;
    end else begin
      cmd_go_r <= cmd_take;
      if (cmd_take) begin
        cmd_r <= '{empty: s_axi_wdata[PINEU_CMD_EMPTY_BIT],
                   op: s_axi_wdata[2:0]};
      end
    end
  end

  // Command interpreter; every branch forms a two-byte answer
  always_comb begin
    state_nxt     = cmd_go_r ? ST_EXEC : ST_IDLE;
    sw_nxt        = sw_r;
    pin_ref_nxt   = pin_ref_r;
    pin_cnt_nxt   = pin_cnt_r;
    unblk_cnt_nxt = unblk_cnt_r;
    enabled_nxt   = enabled_r;
    verified_nxt  = verified_r;
    if (state_r == ST_EXEC) begin
      sw_nxt = '{sw1: PINEU_SW1_OK, sw2: PINEU_SW2_OK};
      unique case (cmd_r.op)
        PINEU_OP_VERIFY: begin
          if (cmd_r.empty) begin
            sw_nxt = pineu_cnt_sw(pin_cnt_r);
          end else if (pin_blk) begin
            sw_nxt = '{sw1: PINEU_SW1_SEC, sw2: PINEU_SW2_BLOCKED};
          end else if (pin_ok) begin
            pin_cnt_nxt  = PINEU_PIN_TRIES;
            verified_nxt = 1'b1;
          end else begin
            // Count lives across card resets, so blocking spans sessions
            pin_cnt_nxt  = pin_dec;
            verified_nxt = 1'b0;
            sw_nxt       = pineu_cnt_sw(pin_dec);
          end
        end
        PINEU_OP_ENABLE: begin
          if (cmd_r.empty) begin
            sw_nxt = pineu_cnt_sw(pin_cnt_r);
          end else if (pin_blk) begin
            sw_nxt = '{sw1: PINEU_SW1_SEC, sw2: PINEU_SW2_BLOCKED};
          end else if (enabled_r) begin
            sw_nxt = '{sw1: PINEU_SW1_SEC, sw2: PINEU_SW2_COND};
          end else if (pin_ok) begin
            pin_cnt_nxt = PINEU_PIN_TRIES;
            enabled_nxt = 1'b1;
          end else begin
            // Stays disabled on a wrong code
            pin_cnt_nxt = pin_dec;
            sw_nxt      = pineu_cnt_sw(pin_dec);
          end
        end
        PINEU_OP_DISABLE: begin
          if (cmd_r.empty) begin
            sw_nxt = pineu_cnt_sw(pin_cnt_r);
          end else if (pin_blk) begin
            sw_nxt = '{sw1: PINEU_SW1_SEC, sw2: PINEU_SW2_BLOCKED};
          end else if (!enabled_r) begin
            sw_nxt = '{sw1: PINEU_SW1_SEC, sw2: PINEU_SW2_COND};
          end else if (pin_ok) begin
            pin_cnt_nxt = PINEU_PIN_TRIES;
            enabled_nxt = 1'b0;
          end else begin
            pin_cnt_nxt  = pin_dec;
            verified_nxt = 1'b0;
            sw_nxt       = pineu_cnt_sw(pin_dec);
          end
        end
        PINEU_OP_UNBLOCK: begin
          // No check of the PIN's blocked state here
          if (cmd_r.empty) begin
            sw_nxt = pineu_cnt_sw(unblk_cnt_r);
          end else if (unblk_blk) begin
            sw_nxt = '{sw1: PINEU_SW1_SEC, sw2: PINEU_SW2_BLOCKED};
          end else if (unblk_ok) begin
            pin_cnt_nxt   = PINEU_PIN_TRIES;
            pin_ref_nxt   = newpin_r;
            unblk_cnt_nxt = PINEU_UNBLK_TRIES;
            enabled_nxt   = 1'b1;
            verified_nxt  = 1'b1;
          end else begin
            // PIN counter, enable and verify state stay as they are
            unblk_cnt_nxt = unblk_dec;
            sw_nxt        = pineu_cnt_sw(unblk_dec);
          end
        end
        PINEU_OP_STATUS: begin
          // Object with tag 90 is read from the response register
          sw_nxt = '{sw1: PINEU_SW1_OK, sw2: PINEU_SW2_OK};
        end
        PINEU_OP_READ: begin
          if (!access_ok) begin
            sw_nxt = '{sw1: PINEU_SW1_SEC, sw2: PINEU_SW2_DENIED};
          end
        end
        PINEU_OP_CARDRST: begin
          // Session ends; counters and enable state persist
          verified_nxt = 1'b0;
        end
        default: begin
          sw_nxt = '{sw1: PINEU_SW1_BADINS, sw2: PINEU_SW2_OK};
        end
      endcase
    end
  end

  // Engine state; counters stand for non-volatile cells
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= ST_IDLE;
      sw_r        <= '{sw1: PINEU_SW1_OK, sw2: PINEU_SW2_OK};
      pin_ref_r   <= PINEU_PIN_RST;
      pin_cnt_r   <= PINEU_PIN_TRIES;
      unblk_cnt_r <= PINEU_UNBLK_TRIES;
      enabled_r   <= PINEU_ENABLED_RST;
      verified_r  <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      sw_r        <= sw_nxt;
      pin_ref_r   <= pin_ref_nxt;
      pin_cnt_r   <= pin_cnt_nxt;
      unblk_cnt_r <= unblk_cnt_nxt;
      enabled_r   <= enabled_nxt;
      verified_r  <= verified_nxt;
      // Cleared by a new command, set when its answer is ready
      if (cmd_take) begin
        done_r <= 1'b0;
      end else if (state_r == ST_EXEC) begin
        done_r <= 1'b1;
      end
    end
  end

endmodule

/* File: hdl/pineu_pkg.sv */
// Purpose: Shared constants and types for the PIN enable/unblock engine
// Assumes: 32-bit AXI4-Lite register window, 8-bit byte addresses
// Notes:   Codes are compared as whole 32-bit words
package pineu_pkg;

  // Register byte offsets
  localparam logic [7:0] PINEU_OFF_CMD    = 8'h00; // Command, write starts
  localparam logic [7:0] PINEU_OFF_PIN    = 8'h04; // Presented PIN
  localparam logic [7:0] PINEU_OFF_UNBLK  = 8'h08; // Presented unblock code
  localparam logic [7:0] PINEU_OFF_NEWPIN = 8'h0c; // Replacement PIN
  localparam logic [7:0] PINEU_OFF_SW     = 8'h10; // Last status word
  localparam logic [7:0] PINEU_OFF_STATE  = 8'h14; // Engine state
  localparam logic [7:0] PINEU_OFF_RESP   = 8'h18; // PIN status object

  // Field positions
  localparam int PINEU_CMD_EMPTY_BIT = 8;  // Empty data field flag
  localparam int PINEU_ST_DONE       = 0;
  localparam int PINEU_ST_ENABLED    = 1;
  localparam int PINEU_ST_VERIFIED   = 2;
  localparam int PINEU_ST_PIN_BLK    = 3;
  localparam int PINEU_ST_UNBLK_BLK  = 4;
  localparam int PINEU_ST_PIN_CNT    = 8;  // 4 bits
  localparam int PINEU_ST_UNBLK_CNT  = 16; // 4 bits

  // Opcodes of the command register
  localparam logic [2:0] PINEU_OP_VERIFY  = 3'h0;
  localparam logic [2:0] PINEU_OP_ENABLE  = 3'h1;
  localparam logic [2:0] PINEU_OP_DISABLE = 3'h2;
  localparam logic [2:0] PINEU_OP_UNBLOCK = 3'h3;
  localparam logic [2:0] PINEU_OP_STATUS  = 3'h4;
  localparam logic [2:0] PINEU_OP_READ    = 3'h5;
  localparam logic [2:0] PINEU_OP_CARDRST = 3'h6;

  // Status word bytes
  localparam logic [7:0] PINEU_SW1_OK      = 8'h90;
  localparam logic [7:0] PINEU_SW2_OK      = 8'h00;
  localparam logic [7:0] PINEU_SW1_CNT     = 8'h63;
  localparam logic [3:0] PINEU_SW2_CNT_HI  = 4'hc;
  localparam logic [7:0] PINEU_SW1_SEC     = 8'h69;
  localparam logic [7:0] PINEU_SW2_DENIED  = 8'h82;
  localparam logic [7:0] PINEU_SW2_BLOCKED = 8'h83;
  localparam logic [7:0] PINEU_SW2_COND    = 8'h85;
  localparam logic [7:0] PINEU_SW1_BADINS  = 8'h6d;

  // PIN status object
  localparam logic [7:0] PINEU_PS_TAG      = 8'h90;
  localparam logic [7:0] PINEU_PS_ENABLED  = 8'h80;
  localparam logic [7:0] PINEU_PS_DISABLED = 8'h00;

  // Retry limits and power-on values
  localparam logic [3:0]  PINEU_PIN_TRIES   = 4'h3;
  localparam logic [3:0]  PINEU_UNBLK_TRIES = 4'ha;
  localparam logic        PINEU_ENABLED_RST = 1'b1;
  localparam logic [31:0] PINEU_PIN_RST     = 32'h31323334; // Arbitrary
  localparam logic [31:0] PINEU_UNBLK_RST   = 32'h87654321; // Arbitrary
  localparam logic [1:0]  PINEU_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PINEU_RESP_SLVERR = 2'h2;

  // Status word carrier
  typedef struct packed {
    logic [7:0] sw1;
    logic [7:0] sw2;
  } pineu_sw_t;

  // Command register carrier
  typedef struct packed {
    logic       empty;
    logic [2:0] op;
  } pineu_cmd_t;

endpackage

/* File: testbench/pineu_top_asserts.sv */
// Purpose: Bus timing and status shape checks on the top ports
// Assumes: Reads judged by address latched at handshake
// Notes:   Bus timing and shape checks only
`timescale 1ns/10ps
module pineu_top_asserts
  import pineu_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [7:0] ra_r; // Address of the read in flight
  wire        rd_sw = s_axi_rvalid && ra_r == PINEU_OFF_SW;
  wire        rd_st = s_axi_rvalid && ra_r == PINEU_OFF_STATE;
  // Latch read address at its handshake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ra_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_ready_pair:
    assert property (s_axi_awready == s_axi_wready)
    else $error("awready and wready differ");
  chk_aw_pulse:
    assert property ($rose(s_axi_awready) |=> $fell(s_axi_awready))
    else $error("awready longer than one cycle");
  chk_b_follows:
    assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("No write response after handshake");
  chk_b_holds:
    assert property (s_axi_bvalid && !s_axi_bready
                     |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");
  chk_r_follows:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("No read data after handshake");
  chk_r_holds:
    assert property (s_axi_rvalid && !s_axi_rready
                     |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data changed while waiting");
  chk_status_tag:
    assert property (s_axi_rvalid && ra_r == PINEU_OFF_RESP
      |-> s_axi_rdata[31:8] == {16'h0, PINEU_PS_TAG}
          && s_axi_rdata[6:0] == 7'h00)
    else $error("PIN status object malformed");
  chk_count_word:
    assert property (rd_sw && s_axi_rdata[15:8] == PINEU_SW1_CNT
      |-> s_axi_rdata[7:4] == PINEU_SW2_CNT_HI
          && s_axi_rdata[31:16] == 16'h0)
    else $error("Retry count word malformed");
  chk_pin_tries:
    assert property (rd_st |-> s_axi_rdata[11:8] <= PINEU_PIN_TRIES
      && s_axi_rdata[3] == (s_axi_rdata[11:8] == 4'h0))
    else $error("PIN tries and blocked flag disagree");
  chk_unblk_tries:
    assert property (rd_st |-> s_axi_rdata[19:16] <= PINEU_UNBLK_TRIES
      && s_axi_rdata[4] == (s_axi_rdata[19:16] == 4'h0))
    else $error("Unblock tries and blocked flag disagree");
endmodule
bind pineu_top pineu_top_asserts i_pineu_top_asserts (
  .clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready);

/* File: testbench/pineu_host_model.sv */
// Purpose: Terminal side model issuing register bus requests
// Assumes: One write and one read at a time
// Notes:   Released lines show their inverse
`timescale 1ns/10ps
module pineu_host_model
  import pineu_pkg::*;
(
  input  wire logic        clk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0;
    s_axi_wdata = 32'h0;
  end
  // Write; t set on timeout
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, output bit t);
    bit done;
    done = 1'b0;
    r = 2'h3;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        done = 1'b1;
      end
    end
    t = !done;
  endtask
  // Read; data taken where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit t);
    bit done;
    done = 1'b0;
    {d, r} = 34'h0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        {d, r} = {s_axi_rdata, s_axi_rresp};
        done = 1'b1;
      end
    end
    t = !done;
  endtask
endmodule

/* File: testbench/tb_pineu_top.sv */
// Purpose: Self-checking bench for the PIN enable/unblock engine
// Assumes: arst_n is power-up; the card reset is a command
// Notes:   Scenarios inherit the counters
`timescale 1ns/10ps
module tb_pineu_top
  import pineu_pkg::*;
  ;
  localparam logic [15:0] sw_ok  = {PINEU_SW1_OK, PINEU_SW2_OK};
  localparam logic [15:0] sw_den = {PINEU_SW1_SEC, PINEU_SW2_DENIED};
  localparam logic [15:0] sw_blk = {PINEU_SW1_SEC, PINEU_SW2_BLOCKED};
  localparam logic [15:0] sw_dup = {PINEU_SW1_SEC, PINEU_SW2_COND};
  logic        clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fails, cmp_count;
  logic [31:0] pin_v; // Code the card holds now
  logic [31:0] v;     // Last register read
  pineu_top i_pineu_top (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pineu_host_model i_pineu_host_model (.clk, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic summarize();
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A hung bus ends the run
  task automatic tmo(input bit t);
    if (t) begin
      fails++;
      summarize();
    end
  endtask
  // Unmapped places answer with an error response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    bit t;
    i_pineu_host_model.wr(a, d, r, t);
    tmo(t);
    chk("bresp", {30'h0, a > PINEU_OFF_RESP ? 2'h2 : 2'h0}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    bit t;
    i_pineu_host_model.rd(a, d, r, t);
    tmo(t);
    chk("rresp", {30'h0, a > PINEU_OFF_RESP ? 2'h2 : 2'h0}, {30'h0, r});
  endtask
  function automatic logic [15:0] cnt(input logic [3:0] n);
    return {PINEU_SW1_CNT, PINEU_SW2_CNT_HI, n};
  endfunction
  // One command, then its status word
  task automatic run(input logic [2:0] op, input logic e,
                     input logic [15:0] sw);
    wr(PINEU_OFF_CMD, {23'h0, e, 5'h0, op});
    rd(PINEU_OFF_SW, v);
    chk("status word", {16'h0, sw}, v);
  endtask
  task automatic ps(input logic [7:0] s);
    run(PINEU_OP_STATUS, 1'b0, sw_ok);
    rd(PINEU_OFF_RESP, v);
    chk("pin status", {16'h0, PINEU_PS_TAG, s}, v);
  endtask
  task automatic ub(input logic [31:0] c, n, input logic [15:0] sw);
    wr(PINEU_OFF_UNBLK, c);
    wr(PINEU_OFF_NEWPIN, n);
    run(PINEU_OP_UNBLOCK, 1'b0, sw);
  endtask
  // Power-up values and an unmapped place
  task automatic s_bus();
    rd(PINEU_OFF_STATE, v);
    chk("state", 32'h000a0302, v);
    ps(PINEU_PS_ENABLED);
    wr(8'h1c, 32'h0);
    rd(8'h1c, v);
    run(3'h7, 1'b0, {PINEU_SW1_BADINS, PINEU_SW2_OK});
  endtask
  // Wrong enables while disabled, then a good one
  task automatic s_enable();
    wr(PINEU_OFF_PIN, pin_v);
    run(PINEU_OP_DISABLE, 1'b0, sw_ok);
    run(PINEU_OP_CARDRST, 1'b0, sw_ok);
    run(PINEU_OP_READ, 1'b0, sw_ok);
    wr(PINEU_OFF_PIN, ~pin_v);
    run(PINEU_OP_ENABLE, 1'b0, cnt(2));
    run(PINEU_OP_READ, 1'b0, sw_ok);
    ps(PINEU_PS_DISABLED);
    run(PINEU_OP_ENABLE, 1'b0, cnt(1));
    wr(PINEU_OFF_PIN, pin_v);
    run(PINEU_OP_ENABLE, 1'b0, sw_ok);
    ps(PINEU_PS_ENABLED);
    run(PINEU_OP_VERIFY, 1'b1, cnt(3));
    run(PINEU_OP_CARDRST, 1'b0, sw_ok);
    run(PINEU_OP_READ, 1'b0, sw_den);
  endtask
  // Block while disabled, across a card reset
  task automatic s_block();
    run(PINEU_OP_DISABLE, 1'b0, sw_ok);
    wr(PINEU_OFF_PIN, ~pin_v);
    run(PINEU_OP_ENABLE, 1'b0, cnt(2));
    run(PINEU_OP_ENABLE, 1'b0, cnt(1));
    run(PINEU_OP_CARDRST, 1'b0, sw_ok);
    run(PINEU_OP_ENABLE, 1'b0, cnt(0));
    run(PINEU_OP_ENABLE, 1'b0, sw_blk);
    rd(PINEU_OFF_STATE, v);
    chk("pin blocked", 32'h0000_0008, v & 32'h0000_0f0a);
    run(PINEU_OP_READ, 1'b0, sw_ok);
    wr(PINEU_OFF_PIN, pin_v);
    run(PINEU_OP_ENABLE, 1'b0, sw_blk);
    run(PINEU_OP_VERIFY, 1'b1, cnt(0));
    ub(PINEU_UNBLK_RST, 32'h33333333, sw_ok);
    pin_v = 32'h33333333;
    run(PINEU_OP_VERIFY, 1'b1, cnt(3));
    run(PINEU_OP_UNBLOCK, 1'b1, cnt(10));
    ps(PINEU_PS_ENABLED);
    run(PINEU_OP_READ, 1'b0, sw_ok);
    wr(PINEU_OFF_PIN, pin_v);
    run(PINEU_OP_ENABLE, 1'b0, sw_dup);
    run(PINEU_OP_VERIFY, 1'b0, sw_ok);
  endtask
  // Block while enabled: reads refused until unblock
  task automatic s_block_en();
    wr(PINEU_OFF_PIN, ~pin_v);
    run(PINEU_OP_VERIFY, 1'b0, cnt(2));
    run(PINEU_OP_CARDRST, 1'b0, sw_ok);
    run(PINEU_OP_VERIFY, 1'b0, cnt(1));
    run(PINEU_OP_VERIFY, 1'b0, cnt(0));
    wr(PINEU_OFF_PIN, pin_v);
    run(PINEU_OP_VERIFY, 1'b0, sw_blk);
    run(PINEU_OP_READ, 1'b0, sw_den);
    ub(PINEU_UNBLK_RST, pin_v, sw_ok);
    run(PINEU_OP_READ, 1'b0, sw_ok);
  endtask
  // Wrong unblock codes until the unblock code blocks
  task automatic s_unblock();
    ub(~PINEU_UNBLK_RST, pin_v, cnt(9));
    rd(PINEU_OFF_STATE, v);
    chk("pin state", 32'h0000_0302, v & 32'h0000_0f0a);
    for (int i = 8; i > 0; i--) begin
      ub(~PINEU_UNBLK_RST, pin_v, cnt(i[3:0]));
    end
    run(PINEU_OP_CARDRST, 1'b0, sw_ok);
    ub(~PINEU_UNBLK_RST, pin_v, cnt(0));
    ub(PINEU_UNBLK_RST, pin_v, sw_blk);
    run(PINEU_OP_VERIFY, 1'b1, cnt(3));
  endtask
  initial begin
    arst_n = 1'b0;
    fails = 0;
    cmp_count = 0;
    pin_v = PINEU_PIN_RST;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    s_bus();
    s_enable();
    s_block();
    s_block_en();
    s_unblock();
    summarize();
  end
endmodule
